// file: src/phy_mgmt_pkg.sv
package phy_mgmt_pkg;

   // ------------------------------------------------------------------
   // Clock and timing
   // ------------------------------------------------------------------
   localparam int unsigned CLK_FREQ_HZ        = 25_000_000;
   localparam int unsigned ENERGY_TIMEOUT_MS  = 256;
   localparam int unsigned ENERGY_TIMEOUT_CYC = ENERGY_TIMEOUT_MS * (CLK_FREQ_HZ / 1000);

   // ------------------------------------------------------------------
   // Register indices on the management interface
   // ------------------------------------------------------------------
   localparam logic [4:0] REG_FLAGS_IDX  = 5'h1D;
   localparam logic [4:0] REG_MASK_IDX   = 5'h1E;
   localparam logic [4:0] REG_STATUS_IDX = 5'h1F;

   // ------------------------------------------------------------------
   // Field layout
   // ------------------------------------------------------------------
   localparam int FLAG_ENERGY    = 7;
   localparam int FLAG_NEG_DONE  = 6;
   localparam int FLAG_RFAULT    = 5;
   localparam int FLAG_LINK_DOWN = 4;
   localparam int FLAG_ACK       = 3;
   localparam int FLAG_PDFAULT   = 2;
   localparam int FLAG_PAGE      = 1;
   localparam int FLAG_MSB       = 7;
   localparam int STAT_DONE_BIT  = 12;
   localparam int STAT_RSV_MSB   = 11;
   localparam int STAT_RSV_LSB   = 5;
   localparam int STAT_SPD_MSB   = 4;
   localparam int STAT_SPD_LSB   = 2;

   localparam logic [7:0] FLAG_VALID_MASK = 8'hFE;
   localparam logic [6:0] STAT_RSV_RESET  = 7'h02;
   localparam logic [4:0] MGMT_ID_DEFAULT = 5'h01;

   // ------------------------------------------------------------------
   // Management frame fields
   // ------------------------------------------------------------------
   localparam logic [5:0] PREAMBLE_BITS = 6'h20;
   localparam logic [1:0] OP_READ       = 2'h2;
   localparam logic [1:0] OP_WRITE      = 2'h1;
   localparam logic [3:0] HDR_LAST      = 4'hC;
   localparam logic [4:0] DATA_LAST     = 5'h10;

   typedef enum logic [1:0] {ST_IDLE, ST_HDR, ST_TA, ST_DATA} mgmt_state_t;

   // Line and negotiation conditions from the PHY core, same clock.
   typedef struct packed {
      logic       line_energy_valid;
      logic       negotiation_complete;
      logic       remote_fault;
      logic       link_up;
      logic       partner_ack;
      logic       parallel_detect_fault;
      logic       page_received;
      logic [2:0] resolved_speed_duplex;
   } phy_events_t;

endpackage

// file: src/phy_interrupt_status_regs.sv
`timescale 1ns/1ns

module phy_interrupt_status_regs
#(
   parameter int unsigned ENERGY_TIMEOUT_CYCLES = phy_mgmt_pkg::ENERGY_TIMEOUT_CYC
)
(
   input  wire logic                      ref_clk,
   input  wire logic                      reset,
   input  wire logic                      mdc,
   input  wire logic                      mdio_in,
   output logic                           mdio_out,
   output logic                           mdio_oe,
   input  wire phy_mgmt_pkg::phy_events_t phy_events,
   input  wire logic [4:0]                station_id_cfg,
   input  wire logic                      station_id_load,
   output logic                           line_energy_present,
   output logic                           irq
);
   import phy_mgmt_pkg::*;

   localparam int ECW = $clog2(ENERGY_TIMEOUT_CYCLES + 1);
   localparam logic [ECW-1:0] ENERGY_LAST = ECW'(ENERGY_TIMEOUT_CYCLES - 1);

   // -------------------------------------------------------------------
   // Pin synchronisers
   // -------------------------------------------------------------------
   // Three stages per pin; a level counts only once stages two and three agree.
   logic [2:0] mdc_sync_r, mdc_sync_nxt;
   logic [2:0] mdio_sync_r, mdio_sync_nxt;
   logic       mdc_level_r, mdc_level_nxt;
   logic       mdio_level_r, mdio_level_nxt;
   logic       mdc_rise;

   always_comb
   begin
      mdc_sync_nxt   = {mdc_sync_r[1:0], mdc};
      mdio_sync_nxt  = {mdio_sync_r[1:0], mdio_in};
      mdc_level_nxt  = (mdc_sync_r[1] == mdc_sync_r[2]) ? mdc_sync_r[2] : mdc_level_r;
      mdio_level_nxt = (mdio_sync_r[1] == mdio_sync_r[2]) ? mdio_sync_r[2] : mdio_level_r;
   end

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         mdc_sync_r   <= 3'h0;
         mdio_sync_r  <= 3'h0;
         mdc_level_r  <= 1'b0;
         mdio_level_r <= 1'b0;
      end
      else
      begin
         mdc_sync_r   <= mdc_sync_nxt;
         mdio_sync_r  <= mdio_sync_nxt;
         mdc_level_r  <= mdc_level_nxt;
         mdio_level_r <= mdio_level_nxt;
      end
   end

   // Management clock edge as seen inside this domain.
   assign mdc_rise = mdc_level_nxt & ~mdc_level_r;

   // -------------------------------------------------------------------
   // Energy presence timer
   // -------------------------------------------------------------------
   logic [ECW-1:0] energy_idle_r, energy_idle_nxt;
   logic           energy_present_r, energy_present_nxt;
   logic           energy_rise;

   always_comb
   begin
      energy_idle_nxt    = energy_idle_r;
      energy_present_nxt = energy_present_r;
      if (phy_events.line_energy_valid)
      begin
         energy_idle_nxt    = '0;
         energy_present_nxt = 1'b1;
      end
      else if (energy_idle_r == ENERGY_LAST)
      begin
         energy_present_nxt = 1'b0;
      end
      else
      begin
         energy_idle_nxt = energy_idle_r + ECW'(1);
      end
   end

   // Presence starts high after reset, as if energy had just been seen.
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         energy_idle_r    <= '0;
         energy_present_r <= 1'b1;
      end
      else
      begin
         energy_idle_r    <= energy_idle_nxt;
         energy_present_r <= energy_present_nxt;
      end
   end

   assign line_energy_present = energy_present_r;
   assign energy_rise         = energy_present_nxt & ~energy_present_r;

   // -------------------------------------------------------------------
   // Register read decode
   // -------------------------------------------------------------------
   function automatic logic [15:0] read_word(input logic [4:0]  idx,
                                             input logic [7:0]  flags,
                                             input logic [7:0]  mask,
                                             input logic        done,
                                             input logic [6:0]  rsv,
                                             input logic [2:0]  spd);
      logic [15:0] w;
      w = 16'h0000;
      unique case (idx)
         REG_FLAGS_IDX:  w[FLAG_MSB:0] = flags;
         REG_MASK_IDX:   w[FLAG_MSB:0] = mask;
         REG_STATUS_IDX:
         begin
            w[STAT_DONE_BIT]             = done;
            w[STAT_RSV_MSB:STAT_RSV_LSB] = rsv;
            w[STAT_SPD_MSB:STAT_SPD_LSB] = spd;
         end
         default:        w = 16'h0000;
      endcase
      return w;
   endfunction

   // -------------------------------------------------------------------
   // Frame engine and registers
   // -------------------------------------------------------------------
   mgmt_state_t state_r, state_nxt;
   logic [5:0]  ones_r, ones_nxt;
   logic [3:0]  hdr_cnt_r, hdr_cnt_nxt;
   logic [11:0] hdr_r, hdr_nxt;
   logic [4:0]  data_cnt_r, data_cnt_nxt;
   logic [15:0] shift_r, shift_nxt;
   logic        is_read_r, is_read_nxt;
   logic [4:0]  reg_idx_r, reg_idx_nxt;
   logic        out_r, out_nxt;
   logic        oe_r, oe_nxt;
   logic [4:0]  station_id_r, station_id_nxt;
   logic [7:0]  flags_r, flags_nxt;
   logic [7:0]  mask_r, mask_nxt;
   logic [6:0]  stat_rsv_r, stat_rsv_nxt;
   logic        done_r, done_nxt;
   logic [2:0]  speed_r, speed_nxt;
   logic        irq_r, irq_nxt;
   logic [7:0]  cond;
   logic [12:0] hdr_full;
   logic [15:0] wr_word;
   logic        flag_clr;

   // Live event conditions, one per flag position.
   always_comb
   begin
      cond                 = 8'h00;
      cond[FLAG_ENERGY]    = energy_rise;
      cond[FLAG_NEG_DONE]  = phy_events.negotiation_complete;
      cond[FLAG_RFAULT]    = phy_events.remote_fault;
      cond[FLAG_LINK_DOWN] = ~phy_events.link_up;
      cond[FLAG_ACK]       = phy_events.partner_ack;
      cond[FLAG_PDFAULT]   = phy_events.parallel_detect_fault;
      cond[FLAG_PAGE]      = phy_events.page_received;
   end

   assign hdr_full = {hdr_r, mdio_level_r};
   assign wr_word  = {shift_r[14:0], mdio_level_r};

   always_comb
   begin
      state_nxt      = state_r;
      ones_nxt       = ones_r;
      hdr_cnt_nxt    = hdr_cnt_r;
      hdr_nxt        = hdr_r;
      data_cnt_nxt   = data_cnt_r;
      shift_nxt      = shift_r;
      is_read_nxt    = is_read_r;
      reg_idx_nxt    = reg_idx_r;
      out_nxt        = out_r;
      oe_nxt         = oe_r;
      mask_nxt       = mask_r;
      stat_rsv_nxt   = stat_rsv_r;
      flag_clr       = 1'b0;
      station_id_nxt = station_id_load ? station_id_cfg : station_id_r;
      done_nxt       = phy_events.negotiation_complete;
      speed_nxt      = phy_events.resolved_speed_duplex;
      if (mdc_rise)
      begin
         unique case (state_r)
            ST_IDLE:
            begin
               if (mdio_level_r)
                  ones_nxt = (ones_r == PREAMBLE_BITS) ? ones_r : ones_r + 6'h01;
               else
               begin
                  ones_nxt = 6'h00;
                  if (ones_r == PREAMBLE_BITS)
                  begin
                     state_nxt   = ST_HDR;
                     hdr_cnt_nxt = 4'h0;
                  end
               end
            end
            ST_HDR:
            begin
               hdr_nxt     = hdr_full[11:0];
               hdr_cnt_nxt = hdr_cnt_r + 4'h1;
               if (hdr_cnt_r == HDR_LAST)
               begin
                  state_nxt   = ST_IDLE;
                  is_read_nxt = (hdr_full[11:10] == OP_READ);
                  reg_idx_nxt = hdr_full[4:0];
                  if (hdr_full[12] && hdr_full[9:5] == station_id_r &&
                      (hdr_full[11:10] == OP_READ || hdr_full[11:10] == OP_WRITE))
                  begin
                     state_nxt = ST_TA;
                     shift_nxt = read_word(hdr_full[4:0], flags_r, mask_r, done_r,
                                           stat_rsv_r, speed_r);
                     flag_clr  = (hdr_full[11:10] == OP_READ) &&
                                 (hdr_full[4:0] == REG_FLAGS_IDX);
                  end
               end
            end
            ST_TA:
            begin
               // First turnaround bit is floated by the controller; answer the second.
               oe_nxt       = is_read_r;
               out_nxt      = 1'b0;
               data_cnt_nxt = 5'h00;
               state_nxt    = ST_DATA;
            end
            ST_DATA:
            begin
               data_cnt_nxt = data_cnt_r + 5'h01;
               if (is_read_r)
               begin
                  out_nxt   = shift_r[15];
                  shift_nxt = {shift_r[14:0], 1'b0};
                  if (data_cnt_r == DATA_LAST)
                  begin
                     oe_nxt    = 1'b0;
                     out_nxt   = 1'b0;
                     state_nxt = ST_IDLE;
                  end
               end
               else if (data_cnt_r == DATA_LAST)
               begin
                  state_nxt = ST_IDLE;
                  if (reg_idx_r == REG_MASK_IDX)
                     mask_nxt = wr_word[FLAG_MSB:0];
                  if (reg_idx_r == REG_STATUS_IDX)
                     stat_rsv_nxt = wr_word[STAT_RSV_MSB:STAT_RSV_LSB];
               end
               else if (data_cnt_r != 5'h00)
                  shift_nxt = wr_word;
            end
         endcase
      end
      // latch high, reserved bits stay 0
      flags_nxt = ((flag_clr ? 8'h00 : flags_r) | cond) & FLAG_VALID_MASK;
      irq_nxt   = |(flags_nxt & mask_nxt);
   end

   // Sync reset lets the link-down flag take the live link state.
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         state_r      <= ST_IDLE;
         ones_r       <= 6'h00;
         hdr_cnt_r    <= 4'h0;
         hdr_r        <= 12'h000;
         data_cnt_r   <= 5'h00;
         shift_r      <= 16'h0000;
         is_read_r    <= 1'b0;
         reg_idx_r    <= 5'h00;
         out_r        <= 1'b0;
         oe_r         <= 1'b0;
         station_id_r <= MGMT_ID_DEFAULT;
         flags_r      <= cond & (8'h01 << FLAG_LINK_DOWN);
         mask_r       <= 8'h00;
         stat_rsv_r   <= STAT_RSV_RESET;
         done_r       <= 1'b0;
         speed_r      <= 3'h0;
         irq_r        <= 1'b0;
      end
      else
      begin
         state_r      <= state_nxt;
         ones_r       <= ones_nxt;
         hdr_cnt_r    <= hdr_cnt_nxt;
         hdr_r        <= hdr_nxt;
         data_cnt_r   <= data_cnt_nxt;
         shift_r      <= shift_nxt;
         is_read_r    <= is_read_nxt;
         reg_idx_r    <= reg_idx_nxt;
         out_r        <= out_nxt;
         oe_r         <= oe_nxt;
         station_id_r <= station_id_nxt;
         flags_r      <= flags_nxt;
         mask_r       <= mask_nxt;
         stat_rsv_r   <= stat_rsv_nxt;
         done_r       <= done_nxt;
         speed_r      <= speed_nxt;
         irq_r        <= irq_nxt;
      end
   end

   assign mdio_out = out_r;
   assign mdio_oe  = oe_r;
   assign irq      = irq_r;

   // -------------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------------
   a_flag_held: assert property (@(posedge ref_clk) disable iff (reset)
      !flag_clr |=> ((flags_r & $past(flags_r)) == $past(flags_r)))
      else $error("Latched flag dropped without a read.");

   a_flag_sets: assert property (@(posedge ref_clk) disable iff (reset)
      (cond != 8'h00) |=> ((flags_r & $past(cond) & FLAG_VALID_MASK)
                           == ($past(cond) & FLAG_VALID_MASK)))
      else $error("Event condition did not set its flag.");

   a_read_clears: assert property (@(posedge ref_clk) disable iff (reset)
      flag_clr |=> (flags_r == ($past(cond) & FLAG_VALID_MASK)))
      else $error("Flag read did not clear ended conditions.");

   a_flag_reserved: assert property (@(posedge ref_clk) disable iff (reset)
      (flags_r & ~FLAG_VALID_MASK) == 8'h00)
      else $error("Reserved flag bit set.");

   a_mask_reset: assert property (@(posedge ref_clk)
      reset |=> (mask_r == 8'h00 && stat_rsv_r == STAT_RSV_RESET && !irq))
      else $error("Mask or reserved status field wrong after reset.");

   a_irq_follows: assert property (@(posedge ref_clk) disable iff (reset)
      irq == |(flags_r & mask_r))
      else $error("Interrupt output disagrees with enabled flags.");

   a_energy_drop: assert property (@(posedge ref_clk) disable iff (reset)
      (energy_idle_r == ENERGY_LAST && !phy_events.line_energy_valid)
      |=> !line_energy_present ##1 (line_energy_present == $past(phy_events.line_energy_valid, 1)
                                    || line_energy_present))
      else $error("Energy presence did not fall at timeout.");

   a_energy_seen: assert property (@(posedge ref_clk) disable iff (reset)
      phy_events.line_energy_valid |=> line_energy_present && energy_idle_r == '0)
      else $error("Energy presence not restored.");

   a_oe_on_read: assert property (@(posedge ref_clk) disable iff (reset)
      mdio_oe |-> (is_read_r && (state_r == ST_DATA)))
      else $error("Data pin driven outside a read answer.");

   a_status_done: assert property (@(posedge ref_clk) disable iff (reset)
      ##1 (done_r == $past(phy_events.negotiation_complete)))
      else $error("Done indication does not follow negotiation state.");

endmodule

// file: bench/mgmt_station_model.sv
`timescale 1ns/1ns

// ----------------------------------------------------------------
// Station management controller on the serial management link
// ----------------------------------------------------------------
module mgmt_station_model
(
   input  wire logic ref_clk,
   input  wire logic mdio_line,
   output logic      mdc,
   output logic      mdio_drv,
   output logic      mdio_drv_en
);
   import phy_mgmt_pkg::*;

   // Six reference cycles per half period keeps the five-cycle margin around each rise.
   localparam int HALF = 6;

   // The management clock stands low between frames and the data line is released.
   initial
   begin
      mdc         = 1'b0;
      mdio_drv    = 1'b1;
      mdio_drv_en = 1'b0;
   end

   // One whole frame; data changes in the low phase and is sampled just before each rise.
   // addressed station frames
   task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] idx,
                        input logic [15:0] wdata, output logic [15:0] rdata);
      logic [63:0] bits;
      logic [63:0] seen;
      bits = {32'hFFFFFFFF, 2'b01, op, phy, idx, 2'b10, wdata};
      for (int i = 0; i < 64; i++)
      begin
         @(posedge ref_clk);
         mdc         <= 1'b0;
         mdio_drv    <= bits[63-i];
         // A read hands the line over from the first turnaround bit on.
         mdio_drv_en <= (i < 46) || (op == OP_WRITE);
         repeat (HALF - 1) @(posedge ref_clk);
         seen[63-i] = mdio_line;
         @(posedge ref_clk);
         mdc <= 1'b1;
         repeat (HALF - 1) @(posedge ref_clk);
      end
      @(posedge ref_clk);
      mdc         <= 1'b0;
      mdio_drv_en <= 1'b0;
      rdata = seen[15:0];
   endtask
endmodule

// file: bench/phy_interrupt_status_regs_tb.sv
`timescale 1ns/1ns

module phy_interrupt_status_regs_tb;
   import phy_mgmt_pkg::*;

   // ----------------------------------------------------------------
   // Bench setup
   // ----------------------------------------------------------------
   // A short energy timeout keeps the run brief; expectations use the same value.
   localparam int unsigned ENERGY_CYC = 20;
   localparam int          LIMIT      = 60000;

   logic        ref_clk = 1'b0;
   logic        reset   = 1'b1;
   logic        mdc;
   logic        mdio_in;
   logic        mdio_out;
   logic        mdio_oe;
   phy_events_t ev      = '0;
   logic [4:0]  station_id_cfg  = 5'h01;
   logic        station_id_load = 1'b0;
   logic        line_energy_present;
   logic        irq;
   logic        drv;
   logic        drv_en;
   int          mismatches   = 0;
   int          total_checks = 0;
   int          cycles       = 0;
   logic [15:0] rd_data;

   always #20 ref_clk = ~ref_clk;

   // The line has a pull-up, so a released line reads high.
   assign mdio_in = mdio_oe ? mdio_out : (drv_en ? drv : 1'b1);

   phy_interrupt_status_regs #(.ENERGY_TIMEOUT_CYCLES(ENERGY_CYC)) uut
   (
      .ref_clk             (ref_clk),
      .reset               (reset),
      .mdc                 (mdc),
      .mdio_in             (mdio_in),
      .mdio_out            (mdio_out),
      .mdio_oe             (mdio_oe),
      .phy_events          (ev),
      .station_id_cfg      (station_id_cfg),
      .station_id_load     (station_id_load),
      .line_energy_present (line_energy_present),
      .irq                 (irq)
   );

   mgmt_station_model ctl
   (
      .ref_clk     (ref_clk),
      .mdio_line   (mdio_in),
      .mdc         (mdc),
      .mdio_drv    (drv),
      .mdio_drv_en (drv_en)
   );

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic rd(input logic [4:0] phy, input logic [4:0] idx, input logic [15:0] exp);
      ctl.frame(OP_READ, phy, idx, 16'h0000, rd_data);
      chk(rd_data, exp);
   endtask

   task automatic wr(input logic [4:0] phy, input logic [4:0] idx, input logic [15:0] data);
      ctl.frame(OP_WRITE, phy, idx, data, rd_data);
   endtask

   // A one-cycle event on struct bit k, then settle past the next edge.
   task automatic pulse(input int k);
      @(posedge ref_clk);
      ev[k] <= 1'b1;
      @(posedge ref_clk);
      ev[k] <= 1'b0;
      @(negedge ref_clk);
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   // Reset values; the link-down flag follows the line, which is down through reset.
   task automatic test_reset();
      chk({15'h0, irq}, 16'h0000);
      rd(MGMT_ID_DEFAULT, REG_FLAGS_IDX, 16'h0010);
      rd(MGMT_ID_DEFAULT, REG_MASK_IDX, 16'h0000);
      rd(MGMT_ID_DEFAULT, REG_STATUS_IDX, 16'h0040);
      wr(MGMT_ID_DEFAULT, REG_FLAGS_IDX, 16'hFFFF);
      @(posedge ref_clk);
      ev.link_up <= 1'b1;
      rd(MGMT_ID_DEFAULT, REG_FLAGS_IDX, 16'h0010);
      rd(MGMT_ID_DEFAULT, REG_FLAGS_IDX, 16'h0000);
   endtask

   // Negotiation, fault, acknowledge and page sources each set only their own flag, and a read clears it once gone.
   task automatic test_events();
      int fbit [5] = '{6, 5, 3, 2, 1};
      int sbit [5] = '{8, 7, 5, 4, 3};
      for (int i = 0; i < 5; i++)
      begin
         pulse(sbit[i]);
         rd(MGMT_ID_DEFAULT, REG_FLAGS_IDX, 16'h0001 << fbit[i]);
         rd(MGMT_ID_DEFAULT, REG_FLAGS_IDX, 16'h0000);
      end
   endtask

   // A masked source leaves the interrupt low, an enabled one raises it until read.
   task automatic test_mask_irq();
      wr(MGMT_ID_DEFAULT, REG_MASK_IDX, 16'h00FF);
      rd(MGMT_ID_DEFAULT, REG_MASK_IDX, 16'h00FF);
      wr(MGMT_ID_DEFAULT, REG_MASK_IDX, 16'h0040);
      rd(MGMT_ID_DEFAULT, REG_MASK_IDX, 16'h0040);
      pulse(7);
      chk({15'h0, irq}, 16'h0000);
      pulse(8);
      chk({15'h0, irq}, 16'h0001);
      rd(MGMT_ID_DEFAULT, REG_FLAGS_IDX, 16'h0060);
      @(negedge ref_clk);
      chk({15'h0, irq}, 16'h0000);
      wr(MGMT_ID_DEFAULT, REG_MASK_IDX, 16'h0000);
   endtask

   // Four speed and duplex codes with negotiation finished.
   task automatic test_status();
      logic [2:0] codes [4] = '{3'b001, 3'b101, 3'b010, 3'b110};
      @(posedge ref_clk);
      ev.negotiation_complete <= 1'b1;
      for (int i = 0; i < 4; i++)
      begin
         @(posedge ref_clk);
         ev.resolved_speed_duplex <= codes[i];
         wr(MGMT_ID_DEFAULT, REG_STATUS_IDX, 16'h0040);
         rd(MGMT_ID_DEFAULT, REG_STATUS_IDX, {4'b0001, 7'h02, codes[i], 2'b00});
      end
      @(posedge ref_clk);
      ev.negotiation_complete  <= 1'b0;
      ev.resolved_speed_duplex <= 3'b000;
      rd(MGMT_ID_DEFAULT, REG_FLAGS_IDX, 16'h0040);
      rd(MGMT_ID_DEFAULT, REG_STATUS_IDX, 16'h0040);
   endtask

   // Energy returns, sets its flag, then times out after the configured count.
   task automatic test_energy();
      chk({15'h0, line_energy_present}, 16'h0000);
      pulse(9);
      chk({15'h0, line_energy_present}, 16'h0001);
      repeat (ENERGY_CYC - 3) @(negedge ref_clk);
      chk({15'h0, line_energy_present}, 16'h0001);
      repeat (6) @(negedge ref_clk);
      chk({15'h0, line_energy_present}, 16'h0000);
      rd(MGMT_ID_DEFAULT, REG_FLAGS_IDX, 16'h0080);
      rd(MGMT_ID_DEFAULT, REG_FLAGS_IDX, 16'h0000);
   endtask

   // Frames for another station go unanswered and the line stays pulled high.
   task automatic test_station();
      rd(5'h02, REG_MASK_IDX, 16'hFFFF);
      wr(5'h02, REG_MASK_IDX, 16'h00FF);
      // An undefined operation code must not be answered or committed.
      ctl.frame(2'b11, MGMT_ID_DEFAULT, REG_MASK_IDX, 16'h00FF, rd_data);
      chk(rd_data, 16'hFFFF);
      rd(MGMT_ID_DEFAULT, REG_MASK_IDX, 16'h0000);
      rd(MGMT_ID_DEFAULT, 5'h10, 16'h0000);
      @(posedge ref_clk);
      station_id_cfg  <= 5'h03;
      station_id_load <= 1'b1;
      @(posedge ref_clk);
      station_id_load <= 1'b0;
      rd(5'h03, REG_MASK_IDX, 16'h0000);
      rd(MGMT_ID_DEFAULT, REG_MASK_IDX, 16'hFFFF);
   endtask

   // A reset in mid-run with the link up leaves the link-down flag clear and reloads defaults.
   task automatic test_rerun_reset();
      wr(5'h03, REG_MASK_IDX, 16'h00FF);
      @(posedge ref_clk);
      reset <= 1'b1;
      repeat (2) @(posedge ref_clk);
      reset <= 1'b0;
      @(negedge ref_clk);
      chk({15'h0, line_energy_present}, 16'h0001);
      rd(MGMT_ID_DEFAULT, REG_FLAGS_IDX, 16'h0000);
      rd(MGMT_ID_DEFAULT, REG_MASK_IDX, 16'h0000);
      rd(5'h03, REG_MASK_IDX, 16'hFFFF);
   endtask

   // ----------------------------------------------------------------
   // Main sequence and hang guard
   // ----------------------------------------------------------------
   // A cycle ceiling well above the forty-odd frames of the run.
   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == LIMIT)
      begin
         mismatches++;
         conclude();
      end
   end

   initial
   begin
      repeat (16) @(posedge ref_clk);
      reset <= 1'b0;
      @(negedge ref_clk);
      test_reset();
      test_events();
      test_mask_irq();
      test_status();
      test_energy();
      test_station();
      test_rerun_reset();
      conclude();
   end
endmodule
